// file: usb_monitor_pkg.sv
// Shared constants and carrier types for the USB token and flag monitor
package usb_monitor_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_IF_CONTROL = 8'h04;
   localparam logic [7:0] OFS_DEVICE_ADDR = 8'h08;
   localparam logic [7:0] OFS_FLAGS = 8'h1C;
   localparam logic [7:0] OFS_STICKY = 8'h20;
   localparam logic [7:0] OFS_MASKS = 8'h24;
   localparam logic [7:0] OFS_FRAME = 8'h28;
   localparam logic [7:0] OFS_PID = 8'h2C;
   localparam logic [7:0] OFS_ENDPOINT = 8'h30;
   localparam logic [7:0] OFS_EP_SELECT = 8'h34;
   localparam logic [7:0] OFS_OTG_MASK = 8'h38;
   localparam logic [7:0] OFS_PWRSIG = 8'h3C;
   localparam logic [7:0] OFS_PHY_CONTROL = 8'h40;

   // Widths
   localparam int NUM_FLAGS = 7;
   localparam int FRAME_W = 11;
   localparam int PWRSIG_W = 9;
   localparam int IF_CONTROL_W = 8;

   // Flag bit positions
   localparam int FLAG_TOKEN = 6;
   localparam int FLAG_SE0 = 5;
   localparam int FLAG_K = 4;
   localparam int FLAG_J = 3;
   localparam int FLAG_CRC16 = 2;
   localparam int FLAG_RX_ACTIVE = 1;
   localparam int FLAG_RX_ERROR = 0;
   // Flags that track a level rather than latch an event
   localparam logic [6:0] LEVEL_FLAGS = 7'h3B;

   // Control field positions
   localparam int IFC_DECODER_EN = 2;
   localparam logic [7:0] IFC_WRITABLE = 8'hF7;
   localparam int PHY_PULLDOWN_DIS = 18;
   localparam int PHY_RESUME_RESET = 13;
   localparam int PHY_RESUME_K = 12;
   localparam int PHY_FILTER_LSB = 8;
   localparam int PHY_RESUME_CTRL = 7;
   localparam int PHY_CONF_LSB = 4;
   localparam int EP_VALID_BIT = 4;

   // Line state encodings
   localparam logic [1:0] LS_SE0 = 2'h0;
   localparam logic [1:0] LS_J = 2'h1;
   localparam logic [1:0] LS_K = 2'h2;

   // Receive-side signals from the transceiver and packet decoder
   typedef struct packed {
      logic [1:0] linestate;
      logic rx_active;
      logic rx_error;
      logic pid_valid;
      logic [3:0] pid;
      logic token_valid;
      logic token_crc5_ok;
      logic token_pid_ok;
      logic [6:0] token_addr;
      logic [3:0] token_endpoint;
      logic crc16_fail;
      logic sof_valid;
      logic [10:0] sof_frame;
   } utmi_rx_s;

   // Register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } reg_req_s;

endpackage

// file: line_state_delay.sv
// Holds back each line-state change for two to the power of a programmable count of clocks
`timescale 1ns/1ns
`default_nettype none
module line_state_delay #(
   parameter int WIDTH = 2,
   parameter int LOG_W = 4
) (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic [WIDTH-1:0] raw_i,
   input wire logic [LOG_W-1:0] log2_i,
   output logic [WIDTH-1:0] filtered_o
);
   localparam int CNT_W = (1 << LOG_W) + 1;

   logic [WIDTH-1:0] candidate;
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] limit;

   assign limit = CNT_W'((CNT_W'(1) << log2_i) - CNT_W'(1));

   // A new value restarts the wait, so glitches shorter than the window never pass
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         candidate <= '0;
         count <= '0;
      end else if (raw_i != candidate) begin
         candidate <= raw_i;
         count <= '0;
      end else if (count != limit) begin
         count <= CNT_W'(count + CNT_W'(1));
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         filtered_o <= '0;
      end else if (raw_i == candidate && count == limit) begin
         filtered_o <= candidate;
      end
   end

endmodule // line_state_delay
`default_nettype wire

// file: usb_token_flag_monitor.sv
// Line and token flag monitor with frame, packet id and endpoint capture
//
// What this block does
// - Non-sticky flags clear on next packet and track later source changes.
// - Sticky-selected flags hold until software writes one to that bit.
// - Token flag sets on token with good CRC5, good PID, matching address.
// - Bits 5, 4, 3 set on SE0, K and J line states.
// - Bit 2 sets when a data packet fails CRC16.
// - Bit 1 follows receive active, bit 0 follows receive error.
// - Each flag port is high when any flag selected by its mask is high.
// - Readable, writable eleven-bit frame counter split at bits 10:8 and 7:0.
// - Packet id of the latest packet captured read-only.
// - Latest endpoint captured read-only with valid bit 4.
// - Selected endpoints go out on the receive port ORed with 0x10.
// - PHY control bit 18 disables the port pull-downs.
// - Auto-resume sets bit 13 for SE0, bit 12 for K; writing zero clears.
// - Line-state changes propagate after two to the filter-field clocks.
// - Bit 7 hands resume to the suspend controller, else software polls.
// - PHY configuration pins driven from the three-bit configuration field.
// - Token address matching compares against the seven-bit device address.
// - Line-state flags only work while the decoder enable bit is set.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module usb_token_flag_monitor
   import usb_monitor_pkg::*;
#(
   parameter int FILTER_LOG_W = 4,
   parameter int NUM_ENDPOINTS = 16
) (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire utmi_rx_s rx_i,
   input wire logic auto_resume_reset_i,
   input wire logic auto_resume_k_i,
   output logic flag_port_a_o,
   output logic flag_port_b_o,
   output logic flag_port_c_o,
   output logic [4:0] rx_endpoint_o,
   output logic rx_endpoint_valid_o,
   output logic [1:0] linestate_filt_o,
   output logic resume_ctrl_en_o,
   output logic pulldown_disable_o,
   output logic [2:0] phy_config_pins_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   reg_req_s req;
   logic [IF_CONTROL_W-1:0] if_control;
   logic [6:0] device_addr;
   logic [NUM_FLAGS-1:0] flags;
   logic [NUM_FLAGS-1:0] flag_hold_select;
   logic [31:0] flag_port_masks;
   logic [FRAME_W-1:0] frame_count;
   logic [3:0] last_pid_value;
   logic [3:0] last_endpoint_number;
   logic last_endpoint_valid;
   logic [NUM_ENDPOINTS-1:0] special_endpoint_bits;
   logic [31:0] otg_flag_mask;
   logic [PWRSIG_W-1:0] power_signalling;
   logic pulldown_disable;
   logic resume_reset_seen;
   logic resume_k_seen;
   logic [FILTER_LOG_W-1:0] linestate_filter_log2;
   logic resume_ctrl_en;
   logic [2:0] phy_config;

   logic rx_active_q;
   logic packet_start;
   logic token_ok;
   logic [1:0] ls_filt;
   logic [NUM_FLAGS-1:0] flag_src;
   logic [NUM_FLAGS-1:0] flag_w1c;
   logic [NUM_FLAGS-1:0] next_flags;
   logic [31:0] next_rdata;

   assign req = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

   function automatic logic wr_hit(input reg_req_s r, input logic [7:0] ofs);
      return r.wr && r.addr == ofs;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Software-written control

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         if_control <= '0;
         device_addr <= '0;
         flag_hold_select <= '0;
         flag_port_masks <= '0;
         special_endpoint_bits <= '0;
         otg_flag_mask <= '0;
         power_signalling <= '0;
      end else begin
         if (wr_hit(req, OFS_IF_CONTROL)) begin
            if_control <= req.wdata[IF_CONTROL_W-1:0] & IFC_WRITABLE;
         end
         if (wr_hit(req, OFS_DEVICE_ADDR)) begin
            device_addr <= req.wdata[6:0];
         end
         if (wr_hit(req, OFS_STICKY)) begin
            flag_hold_select <= req.wdata[NUM_FLAGS-1:0];
         end
         if (wr_hit(req, OFS_MASKS)) begin
            flag_port_masks <= req.wdata;
         end
         if (wr_hit(req, OFS_EP_SELECT)) begin
            special_endpoint_bits <= req.wdata[NUM_ENDPOINTS-1:0];
         end
         if (wr_hit(req, OFS_OTG_MASK)) begin
            otg_flag_mask <= req.wdata;
         end
         if (wr_hit(req, OFS_PWRSIG)) begin
            power_signalling <= req.wdata[PWRSIG_W-1:0];
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         pulldown_disable <= 1'b0;
         linestate_filter_log2 <= '0;
         resume_ctrl_en <= 1'b0;
         phy_config <= '0;
      end else if (wr_hit(req, OFS_PHY_CONTROL)) begin
         pulldown_disable <= req.wdata[PHY_PULLDOWN_DIS];
         linestate_filter_log2 <= req.wdata[PHY_FILTER_LSB +: FILTER_LOG_W];
         resume_ctrl_en <= req.wdata[PHY_RESUME_CTRL];
         phy_config <= req.wdata[PHY_CONF_LSB +: 3];
      end
   end

   // Hardware set beats a software write in the same cycle
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         resume_reset_seen <= 1'b0;
         resume_k_seen <= 1'b0;
      end else begin
         if (auto_resume_reset_i) begin
            resume_reset_seen <= 1'b1;
         end else if (wr_hit(req, OFS_PHY_CONTROL)) begin
            resume_reset_seen <= req.wdata[PHY_RESUME_RESET];
         end
         if (auto_resume_k_i) begin
            resume_k_seen <= 1'b1;
         end else if (wr_hit(req, OFS_PHY_CONTROL)) begin
            resume_k_seen <= req.wdata[PHY_RESUME_K];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Line state filter and flag sources

   line_state_delay #(
      .WIDTH(2),
      .LOG_W(FILTER_LOG_W)
   ) u_filter (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .raw_i(rx_i.linestate),
      .log2_i(linestate_filter_log2),
      .filtered_o(ls_filt)
   );

   // A packet begins on the rising edge of receive active
   assign packet_start = rx_i.rx_active && !rx_active_q;

   assign token_ok = rx_i.token_valid && rx_i.token_crc5_ok && rx_i.token_pid_ok
                     && rx_i.token_addr == device_addr;

   always_comb begin
      flag_src = '0;
      flag_src[FLAG_TOKEN] = token_ok;
      flag_src[FLAG_SE0] = if_control[IFC_DECODER_EN] && ls_filt == LS_SE0;
      flag_src[FLAG_K] = if_control[IFC_DECODER_EN] && ls_filt == LS_K;
      flag_src[FLAG_J] = if_control[IFC_DECODER_EN] && ls_filt == LS_J;
      flag_src[FLAG_CRC16] = rx_i.crc16_fail;
      flag_src[FLAG_RX_ACTIVE] = rx_i.rx_active;
      flag_src[FLAG_RX_ERROR] = rx_i.rx_error;
   end

   assign flag_w1c = wr_hit(req, OFS_FLAGS) ? req.wdata[NUM_FLAGS-1:0] : '0;

   // Sources always win; held bits fall only to a write of one or, when
   // not sticky, to the next packet. Level flags that are not sticky
   // simply follow their source.
   assign next_flags = flag_src
                       | (flags & flag_hold_select & ~flag_w1c)
                       | (flags & ~flag_hold_select & ~LEVEL_FLAGS & ~flag_w1c
                          & ~{NUM_FLAGS{packet_start}});

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         flags <= '0;
         rx_active_q <= 1'b0;
      end else begin
         flags <= next_flags;
         rx_active_q <= rx_i.rx_active;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame counter, packet id and endpoint capture

   // A software write in the same cycle as a frame start is overridden
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         frame_count <= '0;
      end else if (rx_i.sof_valid) begin
         frame_count <= rx_i.sof_frame;
      end else if (wr_hit(req, OFS_FRAME)) begin
         frame_count <= req.wdata[FRAME_W-1:0];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         last_pid_value <= '0;
      end else if (rx_i.pid_valid) begin
         last_pid_value <= rx_i.pid;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         last_endpoint_number <= '0;
         last_endpoint_valid <= 1'b0;
         rx_endpoint_o <= '0;
         rx_endpoint_valid_o <= 1'b0;
      end else begin
         rx_endpoint_valid_o <= token_ok;
         if (token_ok) begin
            last_endpoint_number <= rx_i.token_endpoint;
            last_endpoint_valid <= 1'b1;
            rx_endpoint_o <= {special_endpoint_bits[rx_i.token_endpoint],
                              rx_i.token_endpoint};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin outputs

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         flag_port_a_o <= 1'b0;
         flag_port_b_o <= 1'b0;
         flag_port_c_o <= 1'b0;
      end else begin
         flag_port_a_o <= |(flags & flag_port_masks[6:0]);
         flag_port_b_o <= |(flags & flag_port_masks[14:8]);
         flag_port_c_o <= |(flags & flag_port_masks[22:16]);
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         linestate_filt_o <= '0;
         resume_ctrl_en_o <= 1'b0;
         pulldown_disable_o <= 1'b0;
         phy_config_pins_o <= '0;
      end else begin
         linestate_filt_o <= ls_filt;
         resume_ctrl_en_o <= resume_ctrl_en;
         pulldown_disable_o <= pulldown_disable;
         phy_config_pins_o <= phy_config;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read port: data stand in the cycle after the strobe, else zero

   always_comb begin
      next_rdata = '0;
      case (req.addr)
         OFS_IF_CONTROL: next_rdata[IF_CONTROL_W-1:0] = if_control;
         OFS_DEVICE_ADDR: next_rdata[6:0] = device_addr;
         OFS_FLAGS: next_rdata[NUM_FLAGS-1:0] = flags;
         OFS_STICKY: next_rdata[NUM_FLAGS-1:0] = flag_hold_select;
         OFS_MASKS: next_rdata = flag_port_masks;
         OFS_FRAME: next_rdata[FRAME_W-1:0] = frame_count;
         OFS_PID: next_rdata[3:0] = last_pid_value;
         OFS_ENDPOINT: next_rdata[EP_VALID_BIT:0] = {last_endpoint_valid,
                                                      last_endpoint_number};
         OFS_EP_SELECT: next_rdata[NUM_ENDPOINTS-1:0] = special_endpoint_bits;
         OFS_OTG_MASK: next_rdata = otg_flag_mask;
         OFS_PWRSIG: next_rdata[PWRSIG_W-1:0] = power_signalling;
         OFS_PHY_CONTROL: begin
            next_rdata[PHY_PULLDOWN_DIS] = pulldown_disable;
            next_rdata[PHY_RESUME_RESET] = resume_reset_seen;
            next_rdata[PHY_RESUME_K] = resume_k_seen;
            next_rdata[PHY_FILTER_LSB +: FILTER_LOG_W] = linestate_filter_log2;
            next_rdata[PHY_RESUME_CTRL] = resume_ctrl_en;
            next_rdata[PHY_CONF_LSB +: 3] = phy_config;
         end
         default: next_rdata = '0;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         rdata_o <= '0;
      end else if (req.rd) begin
         rdata_o <= next_rdata;
      end else begin
         rdata_o <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);

   a_token_flag_set: assert property (token_ok |=> flags[FLAG_TOKEN])
      else $error("token flag not set after good token");
   a_sticky_hold: assert property (
      flags[FLAG_CRC16] && flag_hold_select[FLAG_CRC16] && !flag_w1c[FLAG_CRC16]
      |=> flags[FLAG_CRC16])
      else $error("sticky flag dropped without a clearing write");
   a_nonsticky_clear: assert property (
      flags[FLAG_CRC16] && !flag_hold_select[FLAG_CRC16] && packet_start
      && !rx_i.crc16_fail |=> !flags[FLAG_CRC16])
      else $error("non-sticky flag survived a new packet");
   a_rx_active_follow: assert property (
      !flag_hold_select[FLAG_RX_ACTIVE]
      |=> flags[FLAG_RX_ACTIVE] == $past(rx_i.rx_active))
      else $error("receive active flag does not follow its input");
   a_port_a_mask: assert property (
      ##1 flag_port_a_o == $past(|(flags & flag_port_masks[6:0])))
      else $error("flag port a disagrees with masked flags");
   a_special_endpoint: assert property (
      token_ok |=> rx_endpoint_valid_o
      && rx_endpoint_o[3:0] == $past(rx_i.token_endpoint)
      && rx_endpoint_o[4] == $past(special_endpoint_bits[rx_i.token_endpoint]))
      else $error("receive endpoint or special mark wrong");
   a_resume_set: assert property (
      auto_resume_reset_i |=> resume_reset_seen [*2] or ##1 !resume_reset_seen
      ##0 $past(wr_hit(req, OFS_PHY_CONTROL)))
      else $error("auto-resume reset bit not held");
   a_pid_readback: assert property (
      rd_i && addr_i == OFS_PID |=> rdata_o == {28'h0, $past(last_pid_value)})
      else $error("packet id readback wrong");
   a_conf_pins: assert property (
      wr_hit(req, OFS_PHY_CONTROL) |=> ##1
      phy_config_pins_o == $past(req.wdata[PHY_CONF_LSB +: 3], 2))
      else $error("PHY configuration pins not driven from the field");
   c_token_seen: cover property (token_ok ##1 flag_port_a_o);
   c_sticky_clear: cover property (flags[FLAG_CRC16] && flag_w1c[FLAG_CRC16]);
   c_special_ep: cover property (token_ok ##1 rx_endpoint_o[4]);
   c_auto_resume: cover property (auto_resume_k_i ##1 resume_k_seen);

endmodule // usb_token_flag_monitor
`default_nettype wire

// file: utmi_rx_model.sv
// Transceiver and packet decoder model that drives the monitor's receive inputs
`timescale 1ns/1ns
`default_nettype none
module utmi_rx_model
   import usb_monitor_pkg::*;
(
   input wire logic mclk_i,
   output var utmi_rx_s rx_o
);
   ////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      rx_o = '0;
      rx_o.linestate = LS_J;
   end

   function automatic utmi_rx_s quiet(input utmi_rx_s v);
      quiet = v;
      quiet.pid_valid = 1'b0;
      quiet.token_valid = 1'b0;
      quiet.crc16_fail = 1'b0;
      quiet.sof_valid = 1'b0;
   endfunction

   // Qualifiers turn to their inverse once the strobe drops, so a stale value never matches
   task automatic strobe(input utmi_rx_s v);
      utmi_rx_s q;
      q = quiet(~v);
      q.linestate = v.linestate;
      q.rx_active = v.rx_active;
      q.rx_error = v.rx_error;
      @(posedge mclk_i);
      rx_o <= v;
      @(posedge mclk_i);
      rx_o <= q;
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////
   task automatic token(input logic crc, input logic pid, input logic [6:0] a,
                        input logic [3:0] ep);
      utmi_rx_s v;
      v = quiet(rx_o);
      v.token_valid = 1'b1;
      v.token_crc5_ok = crc;
      v.token_pid_ok = pid;
      v.token_addr = a;
      v.token_endpoint = ep;
      strobe(v);
   endtask

   task automatic pid_pulse(input logic [3:0] p);
      utmi_rx_s v;
      v = quiet(rx_o);
      v.pid_valid = 1'b1;
      v.pid = p;
      strobe(v);
   endtask

   task automatic crc_fail();
      utmi_rx_s v;
      v = quiet(rx_o);
      v.crc16_fail = 1'b1;
      strobe(v);
   endtask

   task automatic sof(input logic [10:0] f);
      utmi_rx_s v;
      v = quiet(rx_o);
      v.sof_valid = 1'b1;
      v.sof_frame = f;
      strobe(v);
   endtask

   task automatic set_rx(input logic act, input logic err);
      @(posedge mclk_i);
      rx_o.rx_active <= act;
      rx_o.rx_error <= err;
   endtask

   task automatic set_line(input logic [1:0] ls);
      @(posedge mclk_i);
      rx_o.linestate <= ls;
   endtask
endmodule // utmi_rx_model
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the USB token and flag monitor
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) \
   begin \
      n_checks++; \
      if ((got) !== (exp)) begin \
         bad_count++; \
         $display("MISMATCH at %0t got %h expected %h", $time, (got), (exp)); \
      end \
   end
module testbench
   import usb_monitor_pkg::*;
;
   typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] e;} row_s;
   logic mclk_i;
   logic nrst_i;
   logic [7:0] addr_i;
   logic [31:0] wdata_i;
   logic wr_i;
   logic rd_i;
   logic [31:0] rdata_o;
   utmi_rx_s rx_i;
   logic auto_resume_reset_i;
   logic auto_resume_k_i;
   logic flag_port_a_o;
   logic flag_port_b_o;
   logic flag_port_c_o;
   logic [4:0] rx_endpoint_o;
   logic rx_endpoint_valid_o;
   logic [1:0] linestate_filt_o;
   logic resume_ctrl_en_o;
   logic pulldown_disable_o;
   logic [2:0] phy_config_pins_o;
   int bad_count = 0;
   int n_checks = 0;
   int n;
   logic [1:0] lsv [3] = '{LS_J, LS_K, LS_SE0};
   logic [31:0] lsf [3] = '{32'h8, 32'h10, 32'h20};
   row_s rows [12] = '{
      '{OFS_IF_CONTROL, 32'hFFFFFFFB, 32'hF3}, '{OFS_DEVICE_ADDR, 32'hFFFFFFFF, 32'h7F},
      '{OFS_FLAGS, 32'hFFFFFFFF, 32'h0}, '{OFS_STICKY, 32'hFFFFFFFF, 32'h7F},
      '{OFS_MASKS, 32'hFFFFFFFF, 32'hFFFFFFFF}, '{OFS_FRAME, 32'hFFFFFFFF, 32'h7FF},
      '{OFS_PID, 32'hFFFFFFFF, 32'h0}, '{OFS_ENDPOINT, 32'hFFFFFFFF, 32'h0},
      '{OFS_EP_SELECT, 32'hFFFFFFFF, 32'hFFFF}, '{OFS_OTG_MASK, 32'hFFFFFFFF, 32'hFFFFFFFF},
      '{OFS_PWRSIG, 32'hFFFFFFFF, 32'h1FF}, '{OFS_PHY_CONTROL, 32'hFFFFFFFF, 32'h43FF0}};

   utmi_rx_model phy (.mclk_i(mclk_i), .rx_o(rx_i));
   usb_token_flag_monitor uut (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_i(rx_i),
      .auto_resume_reset_i(auto_resume_reset_i), .auto_resume_k_i(auto_resume_k_i),
      .flag_port_a_o(flag_port_a_o), .flag_port_b_o(flag_port_b_o),
      .flag_port_c_o(flag_port_c_o), .rx_endpoint_o(rx_endpoint_o),
      .rx_endpoint_valid_o(rx_endpoint_valid_o), .linestate_filt_o(linestate_filt_o),
      .resume_ctrl_en_o(resume_ctrl_en_o), .pulldown_disable_o(pulldown_disable_o),
      .phy_config_pins_o(phy_config_pins_o));

   ////////////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      if (bad_count == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic idle(input int c);
      repeat (c) @(posedge mclk_i);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample just past that edge
   task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge mclk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1;
      `CHK(rdata_o, e)
   endtask

   task automatic pulse(input logic k);
      @(posedge mclk_i);
      if (k) auto_resume_k_i <= 1'b1;
      else auto_resume_reset_i <= 1'b1;
      @(posedge mclk_i);
      auto_resume_k_i <= 1'b0;
      auto_resume_reset_i <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      mclk_i = 1'b0;
      forever #25 mclk_i = ~mclk_i;
   end

   initial begin
      repeat (20000) @(posedge mclk_i);
      bad_count++;
      give_verdict();
   end

   initial begin
      nrst_i = 1'b0;
      addr_i = 8'h00;
      wdata_i = 32'h0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      auto_resume_reset_i = 1'b0;
      auto_resume_k_i = 1'b0;
      repeat (12) @(posedge mclk_i);
      nrst_i <= 1'b1;
      foreach (rows[i]) begin
         chk_rd(rows[i].a, 32'h0);
         wr(rows[i].a, rows[i].w);
         chk_rd(rows[i].a, rows[i].e);
      end
      chk_rd(8'h44, 32'h0);
      `CHK({pulldown_disable_o, resume_ctrl_en_o, phy_config_pins_o}, 5'h1F)
      wr(OFS_PHY_CONTROL, 32'h00040050);
      idle(2);
      `CHK({pulldown_disable_o, resume_ctrl_en_o, phy_config_pins_o}, 5'h15)
      wr(OFS_IF_CONTROL, 32'h0);
      wr(OFS_MASKS, 32'h00040240);
      wr(OFS_EP_SELECT, 32'h8);
      wr(OFS_DEVICE_ADDR, 32'h5);
      wr(OFS_STICKY, 32'h0);
      // Good tokens: one to a special endpoint, one to a plain one
      phy.token(1'b1, 1'b1, 7'h05, 4'h3);
      idle(0);
      `CHK(rx_endpoint_valid_o, 1'b1)
      idle(3);
      `CHK(rx_endpoint_o, 5'h13)
      `CHK(rx_endpoint_valid_o, 1'b0)
      `CHK(flag_port_a_o, 1'b1)
      chk_rd(OFS_FLAGS, 32'h40);
      chk_rd(OFS_ENDPOINT, 32'h13);
      phy.token(1'b1, 1'b1, 7'h05, 4'h2);
      idle(3);
      `CHK(rx_endpoint_o, 5'h02)
      chk_rd(OFS_ENDPOINT, 32'h12);
      wr(OFS_FLAGS, 32'h40);
      for (int i = 0; i < 3; i++) phy.token(i != 0, i != 1, (i == 2) ? 7'h06 : 7'h05, 4'h1);
      idle(3);
      chk_rd(OFS_FLAGS, 32'h0);
      `CHK(flag_port_a_o, 1'b0)
      chk_rd(OFS_ENDPOINT, 32'h12);
      phy.pid_pulse(4'hD);
      idle(2);
      chk_rd(OFS_PID, 32'hD);
      wr(OFS_FRAME, 32'h123);
      chk_rd(OFS_FRAME, 32'h123);
      phy.sof(11'h5A5);
      idle(2);
      chk_rd(OFS_FRAME, 32'h5A5);
      // Packet start wipes plain event flags; levels follow their source
      phy.token(1'b1, 1'b1, 7'h05, 4'h3);
      phy.crc_fail();
      phy.set_rx(1'b1, 1'b0);
      idle(3);
      chk_rd(OFS_FLAGS, 32'h02);
      `CHK(flag_port_b_o, 1'b1)
      phy.set_rx(1'b1, 1'b1);
      idle(3);
      chk_rd(OFS_FLAGS, 32'h03);
      phy.set_rx(1'b0, 1'b0);
      idle(3);
      chk_rd(OFS_FLAGS, 32'h0);
      wr(OFS_STICKY, 32'h46);
      phy.token(1'b1, 1'b1, 7'h05, 4'h3);
      phy.crc_fail();
      phy.set_rx(1'b1, 1'b0);
      idle(3);
      phy.set_rx(1'b0, 1'b0);
      idle(3);
      chk_rd(OFS_FLAGS, 32'h46);
      wr(OFS_FLAGS, 32'h44);
      chk_rd(OFS_FLAGS, 32'h02);
      wr(OFS_FLAGS, 32'h02);
      chk_rd(OFS_FLAGS, 32'h0);
      wr(OFS_STICKY, 32'h0);
      phy.crc_fail();
      idle(3);
      chk_rd(OFS_FLAGS, 32'h04);
      `CHK(flag_port_c_o, 1'b1)
      wr(OFS_FLAGS, 32'h04);
      // Line symbols with the decoder on, then off
      wr(OFS_PHY_CONTROL, 32'h0);
      wr(OFS_IF_CONTROL, 32'h4);
      for (int i = 0; i < 3; i++) begin
         phy.set_line(lsv[i]);
         idle(6);
         chk_rd(OFS_FLAGS, lsf[i]);
      end
      wr(OFS_IF_CONTROL, 32'h0);
      idle(3);
      chk_rd(OFS_FLAGS, 32'h0);
      // Filter of two to the third clocks, plus the output register
      wr(OFS_PHY_CONTROL, 32'h300);
      idle(20);
      phy.set_line(LS_J);
      n = 0;
      while (linestate_filt_o !== LS_J && n < 100) begin
         idle(1);
         n++;
      end
      if (n == 100) begin
         bad_count++;
         give_verdict();
      end
      `CHK((n >= 8) && (n <= 11), 1'b1)
      pulse(1'b0);
      idle(2);
      chk_rd(OFS_PHY_CONTROL, 32'h2300);
      pulse(1'b1);
      idle(2);
      chk_rd(OFS_PHY_CONTROL, 32'h3300);
      wr(OFS_PHY_CONTROL, 32'h300);
      chk_rd(OFS_PHY_CONTROL, 32'h300);
      // Reset in mid-run puts the registers back to zero
      @(posedge mclk_i);
      nrst_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      nrst_i <= 1'b1;
      chk_rd(OFS_MASKS, 32'h0);
      chk_rd(OFS_FRAME, 32'h0);
      give_verdict();
   end
endmodule // testbench
`default_nettype wire
